/* File: rtl/add_exec_pkg.sv */
// Constants, types and register map for the add execution block
package add_exec_pkg;

    // Instruction fields
    localparam int unsigned INSTR_W    = 16;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned BANK_W     = 4;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned DEST_BIT   = 9;
    localparam int unsigned ACCSEL_BIT = 8;

    // Opcodes
    localparam logic [7:0]  OPC_LIT  = 8'h0f;
    localparam logic [5:0]  OPC_ADD  = 6'h09;
    localparam logic [5:0]  OPC_ADDC = 6'h08;
    localparam logic [11:0] OPC_BANK = 12'h010;

    // Addressing
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
    localparam logic [3:0]  ACCESS_LO_PG  = 4'h0;
    localparam logic [3:0]  ACCESS_HI_PG  = 4'hf;

    // Register bus
    localparam int unsigned AXI_ADDR_W   = 5;
    localparam logic [4:0]  REG_CTRL     = 5'h00;
    localparam logic [4:0]  REG_BANK     = 5'h04;
    localparam logic [4:0]  REG_ACC      = 5'h08;
    localparam logic [4:0]  REG_FLAGS    = 5'h0c;
    localparam logic [4:0]  REG_INDEX    = 5'h10;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Reset values
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [3:0]  BANK_RST  = 4'h0;
    localparam logic [11:0] INDEX_RST = 12'h000;
    localparam logic        EXT_RST   = 1'b0;

    // Status flags, carry in bit 0
    typedef struct packed {
        logic n;
        logic overflow_flag;
        logic z;
        logic digit_carry_flag;
        logic c;
    } flags_type;

    localparam flags_type FLAGS_RST = '0;

    // Data memory request
    typedef struct packed {
        logic [11:0] addr;
        logic        rd;
        logic        we;
        logic [7:0]  wdata;
    } mem_req_type;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_LIT, OP_ADD, OP_ADDC, OP_BANK
    } op_type;

endpackage

/* File: rtl/add_nibble.sv */
// Four-bit adder slice with carry in and carry out
`timescale 1ns/1ps
module add_nibble
(
    // Operands
    input  wire logic [3:0] a_i,
    input  wire logic [3:0] b_i,
    input  wire logic       cin_i,
    // Result
    output logic      [3:0] sum_o,
    output logic            cout_o
);
    logic [4:0] full;

    assign full   = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin_i};
    assign sum_o  = full[3:0];
    assign cout_o = full[4];
endmodule

/* File: rtl/add_exec.sv */
// Add instruction execution datapath with AXI4-Lite register access
// Functional notes
// - Literal add puts W plus 8-bit immediate into W; opcode 0000 1111
// - File add sums W and memory byte; opcode 0010 01da ffff ffff
// - Add with carry sums W, memory byte and carry; opcode 0010 00da
// - Destination bit 0 writes W, 1 writes the file byte back
// - Access bit 0 uses access bank; 1 uses bank select register
// - Extended set, access bit 0, address up to 5Fh: indexed offset
// - All three adds update negative, overflow, carry, digit carry, zero flags
// - Each add is one word and one instruction cycle
// - Decode Q1, read operand Q2, compute Q3, write destination Q4
// - File address is 8 bits; destination and access are one bit each
// - Bank select register is 4 bits, loaded by move-literal instruction
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module add_exec
    import add_exec_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                         clk_sys_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         ce_i,
    // Instruction fetch
    input  wire logic [15:0]                  instr_i,
    input  wire logic                         instr_valid_i,
    output logic                              instr_ready_o,
    output logic                              done_o,
    // Data memory
    output add_exec_pkg::mem_req_type         mem_req_o,
    input  wire logic [7:0]                   mem_rdata_i,
    // Flags
    output add_exec_pkg::flags_type           flags_o,
    // AXI4-Lite write
    input  wire logic [4:0]                   s_axi_awaddr_i,
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [31:0]                  s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    output logic [1:0]                        s_axi_bresp_o,
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [4:0]                   s_axi_araddr_i,
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    output logic [31:0]                       s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i
);
    import add_exec_pkg::*;

    phase_type   phase_r;
    op_type      op_r;
    op_type      op_nxt;
    logic [15:0] instr_r;
    logic        dest_r;
    logic        ready_r;
    logic        done_r;
    mem_req_type mem_r;
    logic [11:0] addr_nxt;
    logic [7:0]  acc_r;
    logic [3:0]  bank_r;
    logic [11:0] index_r;
    logic        ext_r;
    flags_type   flags_r;
    flags_type   flags_calc;
    flags_type   res_flags_r;
    logic [7:0]  result_r;
    logic [7:0]  add_b;
    logic        add_cin;
    logic [7:0]  sum;
    logic        c3;
    logic        c7;
    logic        take_w;
    logic        commit_w;
    logic        is_add_r;
    logic [7:0]  f_fld;
    logic        d_fld;
    logic        a_fld;
    // Bus side
    logic        aw_held_r;
    logic        w_held_r;
    logic [4:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic        rd_err;
    logic        bus_wr;
    logic        wr_err;
    logic        lane0;

    ////////////////////////////////////////////////////////////////////
    // Decode and addressing
    assign take_w   = ce_i && (phase_r == PH_Q1) && instr_valid_i;
    assign commit_w = ce_i && (phase_r == PH_Q4);
    assign f_fld = instr_i[7:0];
    assign d_fld = instr_i[DEST_BIT];
    assign a_fld = instr_i[ACCSEL_BIT];

    always_comb
    begin
        op_nxt = OP_NONE;
        if (instr_i[15:8] == OPC_LIT)
            op_nxt = OP_LIT;
        else if (instr_i[15:10] == OPC_ADD)
            op_nxt = OP_ADD;
        else if (instr_i[15:10] == OPC_ADDC)
            op_nxt = OP_ADDC;
        else if (instr_i[15:4] == OPC_BANK)
            op_nxt = OP_BANK;
    end

    always_comb
    begin
        if (a_fld)
            addr_nxt = {bank_r, f_fld};
        else if (ext_r && (f_fld <= IDX_LIMIT))
            addr_nxt = index_r + {ACCESS_LO_PG, f_fld};
        else if (f_fld <= IDX_LIMIT)
            addr_nxt = {ACCESS_LO_PG, f_fld};
        else
            addr_nxt = {ACCESS_HI_PG, f_fld};
    end

    ////////////////////////////////////////////////////////////////////
    // Phase sequencer
    // four phases
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            phase_r <= PH_Q1;
        else if (ce_i)
        begin
            case (phase_r)
                PH_Q1:   phase_r <= PH_Q2;
                PH_Q2:   phase_r <= PH_Q3;
                PH_Q3:   phase_r <= PH_Q4;
                PH_Q4:   phase_r <= PH_Q1;
                default: phase_r <= PH_Q1;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ready_r <= 1'b1;
            done_r  <= 1'b0;
        end
        else if (ce_i)
        begin
            ready_r <= (phase_r == PH_Q4);
            done_r  <= (phase_r == PH_Q4) && (op_r != OP_NONE);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            op_r     <= OP_NONE;
            instr_r  <= '0;
            dest_r   <= 1'b0;
            is_add_r <= 1'b0;
        end
        else if (ce_i && (phase_r == PH_Q1))
        begin
            op_r     <= take_w ? op_nxt : OP_NONE;
            instr_r  <= instr_i;
            dest_r   <= take_w && d_fld && (op_nxt inside {OP_ADD, OP_ADDC});
            is_add_r <= take_w && (op_nxt inside {OP_LIT, OP_ADD, OP_ADDC});
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Adder and flags
    assign add_b   = (op_r == OP_LIT) ? instr_r[7:0] : mem_rdata_i;
    assign add_cin = (op_r == OP_ADDC) && flags_r.c;

    add_nibble u_lo
    (
        .a_i    (acc_r[3:0]),
        .b_i    (add_b[3:0]),
        .cin_i  (add_cin),
        .sum_o  (sum[3:0]),
        .cout_o (c3)
    );

    add_nibble u_hi
    (
        .a_i    (acc_r[7:4]),
        .b_i    (add_b[7:4]),
        .cin_i  (c3),
        .sum_o  (sum[7:4]),
        .cout_o (c7)
    );

    always_comb
    begin
        flags_calc.c                = c7;
        flags_calc.digit_carry_flag = c3;
        flags_calc.overflow_flag    = (acc_r[7] ^ add_b[7] ^ sum[7]) ^ c7;
        flags_calc.n                = sum[7];
        flags_calc.z                = (sum == '0);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            result_r    <= '0;
            res_flags_r <= FLAGS_RST;
        end
        else if (ce_i && (phase_r == PH_Q3))
        begin
            result_r    <= sum;
            res_flags_r <= flags_calc;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data memory port
    // read in Q2, write in Q4
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            mem_r <= '0;
        else if (ce_i)
        begin
            case (phase_r)
                PH_Q1:
                begin
                    mem_r.addr <= addr_nxt;
                    mem_r.rd   <= take_w && (op_nxt inside {OP_ADD, OP_ADDC});
                end
                PH_Q2:
                    mem_r.rd <= 1'b0;
                PH_Q3:
                begin
                    mem_r.we    <= dest_r;
                    mem_r.wdata <= sum;
                end
                PH_Q4:
                    mem_r.we <= 1'b0;
                default:
                    mem_r <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Architectural registers, core update wins over bus write
    assign lane0 = w_strb_r[0];

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            acc_r <= ACC_RST;
        else if (commit_w && is_add_r && !dest_r)
            acc_r <= result_r;
        else if (bus_wr && (aw_addr_r == REG_ACC) && lane0)
            acc_r <= w_data_r[7:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            flags_r <= FLAGS_RST;
        else if (commit_w && is_add_r)
            flags_r <= res_flags_r;
        else if (bus_wr && (aw_addr_r == REG_FLAGS) && lane0)
            flags_r <= w_data_r[4:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            bank_r <= BANK_RST;
        else if (commit_w && (op_r == OP_BANK))
            bank_r <= instr_r[3:0];
        else if (bus_wr && (aw_addr_r == REG_BANK) && lane0)
            bank_r <= w_data_r[3:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ext_r   <= EXT_RST;
            index_r <= INDEX_RST;
        end
        else if (bus_wr)
        begin
            if ((aw_addr_r == REG_CTRL) && lane0)
                ext_r <= w_data_r[0];
            if ((aw_addr_r == REG_INDEX) && lane0)
                index_r[7:0] <= w_data_r[7:0];
            if ((aw_addr_r == REG_INDEX) && w_strb_r[1])
                index_r[11:8] <= w_data_r[11:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    assign bus_wr = ce_i && aw_held_r && w_held_r && !bvalid_r;
    assign wr_err = !(aw_addr_r inside
                      {REG_CTRL, REG_BANK, REG_ACC, REG_FLAGS, REG_INDEX});

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid_i && awready_r)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_r)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
                wready_r <= 1'b0;
            end
            if (bus_wr)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready_i)
            begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_comb
    begin
        rd_nxt = '0;
        rd_err = 1'b0;
        case (s_axi_araddr_i)
            REG_CTRL:  rd_nxt[0]    = ext_r;
            REG_BANK:  rd_nxt[3:0]  = bank_r;
            REG_ACC:   rd_nxt[7:0]  = acc_r;
            REG_FLAGS: rd_nxt[4:0]  = flags_r;
            REG_INDEX: rd_nxt[11:0] = index_r;
            default:   rd_err       = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid_i && arready_r)
            begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_nxt;
                rresp_r   <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            else if (rvalid_r && s_axi_rready_i)
            begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign instr_ready_o   = ready_r;
    assign done_o          = done_r;
    assign mem_req_o       = mem_r;
    assign flags_o         = flags_r;
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rdata_o   = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_take(op_type o, logic d);
        take_w && (op_nxt == o) && (d_fld == d);
    endsequence

    sequence s_run3;
        ce_i [*3];
    endsequence

    a_phase_order: assert property ((ce_i && phase_r == PH_Q1) |=>
        (phase_r == PH_Q2) ##0 (!ce_i || 1'b1))
        else $error("Phase Q1 not followed by Q2");

    a_lit_sum: assert property (s_take(OP_LIT, d_fld) ##1 s_run3 |=>
        acc_r == 8'($past(acc_r, 2) + instr_r[7:0]))
        else $error("Literal add result wrong");

    a_file_write: assert property (s_take(OP_ADD, 1'b1) ##1 ce_i [*2]
        |=> mem_r.we && mem_r.wdata == 8'($past(acc_r) + $past(mem_rdata_i)))
        else $error("File add write back wrong");

    a_carry_add: assert property (s_take(OP_ADDC, 1'b0) ##1 s_run3 |=>
        acc_r == 8'($past(acc_r, 2) + $past(mem_rdata_i, 2)
                    + {7'h00, $past(flags_r.c, 2)}))
        else $error("Add with carry result wrong");

    a_bank_addr: assert property ((take_w && a_fld &&
        (op_nxt inside {OP_ADD, OP_ADDC})) |=>
        mem_r.rd && mem_r.addr == {$past(bank_r), instr_r[7:0]})
        else $error("Banked address wrong");

    a_index_addr: assert property ((take_w && !a_fld && ext_r &&
        f_fld <= IDX_LIMIT) |=>
        mem_r.addr == 12'($past(index_r) + {4'h0, instr_r[7:0]}))
        else $error("Indexed address wrong");

    a_flag_update: assert property ((commit_w && is_add_r) |=>
        flags_r.z == ($past(result_r) == 8'h00) &&
        flags_r.n == $past(res_flags_r.n) && $stable(result_r))
        else $error("Flags not taken from result");

    a_carry_ov: assert property ((ce_i && phase_r == PH_Q3) |=>
        res_flags_r.c == $past(c7) &&
        res_flags_r.overflow_flag ==
            ($past(acc_r[7]) == $past(add_b[7]) &&
             $past(sum[7]) != $past(acc_r[7])))
        else $error("Carry or overflow wrong");

    a_one_cycle: assert property (s_take(OP_ADD, d_fld) ##1 s_run3
        |=> done_r)
        else $error("Add not done in one cycle");

    a_bank_move: assert property ((commit_w && op_r == OP_BANK) |=>
        bank_r == $past(instr_r[3:0]))
        else $error("Bank select not loaded");

    a_dest_w: assert property (s_take(OP_ADD, 1'b0) ##1 ce_i [*2]
        |=> !mem_r.we)
        else $error("Write to file with W destination");

    a_idle_no_write: assert property (
        (ce_i && phase_r == PH_Q1 && !take_w) ##1 ce_i [*2] |=> !mem_r.we)
        else $error("File write without an instruction");
endmodule

/* File: bench/mem_model.sv */
// Data memory model facing the add execution block
`timescale 1ns/1ps
module mem_model
    import add_exec_pkg::*;
(
    // Clock
    input  wire logic                      clk_sys_i,
    // Memory port
    input  wire add_exec_pkg::mem_req_type mem_req_i,
    output logic [7:0]                     mem_rdata_o
);
    logic [7:0] data [4096];

    initial mem_rdata_o = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Read byte for one cycle, otherwise a pattern that toggles
    always @(posedge clk_sys_i)
    begin
        if (mem_req_i.rd)
            mem_rdata_o <= data[mem_req_i.addr];
        else
            mem_rdata_o <= ~mem_rdata_o;
        if (mem_req_i.we)
            data[mem_req_i.addr] <= mem_req_i.wdata;
    end
endmodule

/* File: bench/add_exec_bench.sv */
// Self-checking bench for the add execution block
`timescale 1ns/1ps
module add_exec_bench;
    import add_exec_pkg::*;

    typedef struct packed {
        logic [1:0]  op;
        logic        d, a, ext, ci;
        logic [7:0]  f, w, m;
        logic [11:0] addr;
    } case_type;

    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [15:0] iw = 16'h0000;
    logic        iv = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
    logic        ar_v = 1'b0, r_r = 1'b0;
    logic [4:0]  aw_a = 5'h00, ar_a = 5'h00;
    logic [31:0] w_d = 32'h0;
    logic        instr_ready_o, done_o, awready, wready, bvalid;
    logic        arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  mem_rdata;
    mem_req_type mem_req_o;
    flags_type   flags_o;
    int          errors = 0;
    int          comparisons = 0;
    case_type    tc [9];

    add_exec dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .instr_i(iw), .instr_valid_i(iv), .instr_ready_o(instr_ready_o),
        .done_o(done_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata),
        .flags_o(flags_o), .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
        .s_axi_awready_o(awready), .s_axi_wdata_i(w_d),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a),
        .s_axi_arvalid_i(ar_v), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(r_r));

    mem_model mem (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o),
        .mem_rdata_o(mem_rdata));

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(logic [4:0] ad, logic [31:0] dt, logic [1:0] rsp);
        logic ta, tw, tb;
        aw_a <= ad;
        w_d  <= dt;
        aw_v <= 1'b1;
        w_v  <= 1'b1;
        b_r  <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clk_sys_i);
            ta = (aw_v & awready) === 1'b1;
            tw = (w_v & wready) === 1'b1;
            tb = bvalid === 1'b1;
            if (tb)
                chk(bresp, rsp);
            @(posedge clk_sys_i);
            if (ta)
                aw_v <= 1'b0;
            if (tw)
                w_v <= 1'b0;
        end
        b_r <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(logic [4:0] ad, logic [31:0] exp, logic [1:0] rsp);
        logic ta, tr;
        ar_a <= ad;
        ar_v <= 1'b1;
        r_r  <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge clk_sys_i);
            ta = (ar_v & arready) === 1'b1;
            tr = rvalid === 1'b1;
            if (tr)
            begin
                chk(rdata, exp);
                chk(rresp, rsp);
            end
            @(posedge clk_sys_i);
            if (ta)
                ar_v <= 1'b0;
        end
        r_r <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic issue(logic [15:0] word, logic rdx, logic wex);
        iw <= word;
        iv <= 1'b1;
        do @(negedge clk_sys_i); while (instr_ready_o !== 1'b1);
        @(posedge clk_sys_i);
        iv <= 1'b0;
        @(negedge clk_sys_i);
        chk(mem_req_o.rd, rdx);
        @(negedge clk_sys_i);
        chk(done_o, 1'b0);
        @(negedge clk_sys_i);
        chk(mem_req_o.we, wex);
        @(negedge clk_sys_i);
        chk(done_o, 1'b1);
        @(posedge clk_sys_i);
    endtask

    function automatic logic [12:0] add_ref(logic [7:0] a, logic [7:0] b,
                                            logic ci);
        logic [8:0] s;
        logic [4:0] l;
        logic       ov;
        l = a[3:0] + b[3:0] + ci;
        s = a + b + ci;
        ov = (a[7] == b[7]) && (s[7] != a[7]);
        return {s[7], ov, s[7:0] == 8'h00, l[4], s[8], s[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        case_type       c;
        logic [12:0]    r;
        logic [15:0]    word;
        logic [7:0]     exp_byte;
        tc = '{'{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h15, 8'h10, 8'h00, 12'h000},
               '{2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 8'h01, 8'h7f, 8'h00, 12'h000},
               '{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h01, 8'hff, 8'h00, 12'h000},
               '{2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 8'h20, 8'h17, 8'hc2, 12'h020},
               '{2'h1, 1'h1, 1'h1, 1'h0, 1'h0, 8'h40, 8'h55, 8'haa, 12'h340},
               '{2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 8'h60, 8'h08, 8'h08, 12'hf60},
               '{2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 8'h10, 8'hf0, 8'h20, 12'h110},
               '{2'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'h5f, 8'h80, 8'h80, 12'h15f},
               '{2'h2, 1'h1, 1'h0, 1'h1, 1'h0, 8'h60, 8'h01, 8'h02, 12'hf60}};
        for (int i = 0; i < 4096; i++)
            mem.data[i] = 8'h00;
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(REG_ACC, 32'h0, RESP_OKAY);
        rd(REG_FLAGS, 32'h0, RESP_OKAY);
        rd(REG_BANK, 32'h0, RESP_OKAY);
        rd(5'h14, 32'h0, RESP_SLVERR);
        wr(REG_INDEX, 32'h100, RESP_OKAY);
        issue({OPC_BANK, 4'h3}, 1'b0, 1'b0);
        rd(REG_BANK, 32'h3, RESP_OKAY);
        $display("Test reset and bank load done");
        foreach (tc[i])
        begin
            c = tc[i];
            r = add_ref(c.w, c.op == 2'h0 ? c.f : c.m,
                        c.op == 2'h2 ? c.ci : 1'b0);
            word = c.op == 2'h0 ? {OPC_LIT, c.f} :
                   {(c.op == 2'h1) ? OPC_ADD : OPC_ADDC, c.d, c.a, c.f};
            wr(REG_CTRL, {31'h0, c.ext}, RESP_OKAY);
            wr(REG_ACC, {24'h0, c.w}, RESP_OKAY);
            wr(REG_FLAGS, {31'h0, c.ci}, RESP_OKAY);
            if (c.op != 2'h0)
                mem.data[c.addr] = c.m;
            issue(word, c.op != 2'h0, c.op != 2'h0 && c.d);
            chk(flags_o, r[12:8]);
            exp_byte = (c.op != 2'h0 && c.d) ? c.w : r[7:0];
            rd(REG_ACC, {24'h0, exp_byte}, RESP_OKAY);
            exp_byte = c.d ? r[7:0] : c.m;
            if (c.op != 2'h0)
                chk(mem.data[c.addr], exp_byte);
            $display("Test case %0d done", i);
        end
        repeat (8) @(posedge clk_sys_i);
        chk(mem.data[12'hf60], 8'h03);
        $display("Test idle write-back done");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule
